// [core/evs_pkg.sv]
`default_nettype none
package evs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned GADDR_W = 18;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INDEX = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PARAM = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h14;

  // field positions
  localparam int unsigned CFG_IRQEN_BIT = 0;
  localparam int unsigned CFG_LOCK_BIT = 1;
  localparam int unsigned ST_COMPLETE_BIT = 7;
  localparam int unsigned ST_ACCESS_BIT = 5;
  localparam int unsigned ST_PROTECT_BIT = 4;
  localparam int unsigned ST_BUSY_BIT = 3;
  localparam int unsigned ST_MG1_BIT = 1;
  localparam int unsigned ST_MG0_BIT = 0;
  localparam int unsigned EV_DONE_BIT = 0;
  localparam int unsigned EV_ACC_BIT = 1;
  localparam int unsigned EV_VFAIL_BIT = 2;

  // reset values and codes
  localparam logic [1:0] CONFIG_RST = 2'h0;
  localparam logic [2:0] INDEX_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] CMD_SECTION_VERIFY = 8'h10;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_FIRST = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    EVS_IDLE = 3'b001,
    EVS_CHECK = 3'b010,
    EVS_SCAN = 3'b100
  } evs_state_t;
endpackage
`default_nettype wire

// [core/evs_axil.sv]
`default_nettype none
module evs_axil import evs_pkg::*; (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic wr_en, // register write strobe
  output logic [ADDR_W-1:0] wr_addr, // held write address
  output logic [31:0] wr_data, // held write data
  output logic [3:0] wr_strb, // held byte enables
  input wire logic wr_ok, // write address is mapped
  output logic rd_en, // register read strobe
  output logic [ADDR_W-1:0] rd_addr, // held read address
  input wire logic [31:0] rd_data, // selected register value
  input wire logic rd_ok // read address is mapped
);
  logic aw_held;
  logic w_held;
  logic ar_held;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !ar_held && !s_axi_rvalid;
  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign rd_en = ar_held && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held <= 1'b0;
      rd_addr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_held <= 1'b1;
        rd_addr <= s_axi_araddr;
      end else if (rd_en) begin
        ar_held <= 1'b0;
      end
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/evs_scan.sv]
`default_nettype none
module evs_scan import evs_pkg::*; (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset
  input wire logic start, // one-cycle start pulse
  input wire logic [GADDR_W-1:0] first_addr, // first word address
  input wire logic [15:0] word_count, // words to check
  output logic mem_req, // read request, held per word
  output logic [GADDR_W-1:0] mem_addr, // word address
  input wire logic [15:0] mem_rdata, // read word
  input wire logic mem_rvalid, // read word valid
  input wire logic mem_ecc_fix, // corrected read fault
  input wire logic mem_ecc_fatal, // uncorrectable read fault
  output logic done, // one-cycle end pulse
  output logic any_err, // any fault or non-blank word
  output logic fatal_err // fatal fault or non-blank word
);
  logic active;
  logic [15:0] left;
  logic not_blank;

  assign mem_req = active && (left != 16'h0000);
  assign not_blank = mem_rdata != ERASED_WORD;

  // every word is read even after a failure, so both verdicts are complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      left <= '0;
      mem_addr <= '0;
      done <= 1'b0;
      any_err <= 1'b0;
      fatal_err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        active <= 1'b1;
        left <= word_count;
        mem_addr <= first_addr;
        any_err <= 1'b0;
        fatal_err <= 1'b0;
      end else if (active && left == 16'h0000) begin
        active <= 1'b0;
        done <= 1'b1;
      end else if (mem_req && mem_rvalid) begin
        left <= left - 16'h0001;
        mem_addr <= mem_addr + 18'h00002;
        if (not_blank || mem_ecc_fix || mem_ecc_fatal) begin
          any_err <= 1'b1;
        end
        if (not_blank || mem_ecc_fatal) begin
          fatal_err <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [core/evs_top.sv]
// What this block does
// - clearing the complete flag launches a blank check of the chosen section
// - the complete flag sets once the section check has finished
// - access error when the parameter index is not 010 at launch
// - access error when the command is unavailable in the current mode
// - access error when the 18-bit address is not inside the EEPROM
// - access error when address bit 0 is set
// - access error when the section runs past the EEPROM end
// - upper verify status sets on any read fault or non-blank word
// - lower verify status sets on fatal fault or non-blank word
// - interrupt requested while complete flag and its enable are both set
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module evs_top import evs_pkg::*; #(
  parameter logic [GADDR_W-1:0] EE_START = 18'h00400, // first EEPROM byte
  parameter logic [GADDR_W-1:0] EE_BYTES = 18'h00600 // EEPROM size in bytes
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic mem_req, // EEPROM read request
  output logic [GADDR_W-1:0] mem_addr, // EEPROM word address
  input wire logic [15:0] mem_rdata, // EEPROM read word
  input wire logic mem_rvalid, // EEPROM read word valid
  input wire logic mem_ecc_fix, // corrected read fault
  input wire logic mem_ecc_fatal, // uncorrectable read fault
  output logic irq // level interrupt
);
  localparam logic [19:0] EE_END = {2'b00, EE_START} + {2'b00, EE_BYTES};

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  evs_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // registers
  logic [1:0] config_reg;
  logic [2:0] param_index;
  logic [15:0] command_param_word [0:7];
  logic command_complete_flag;
  logic access_error_flag;
  logic verify_status_upper;
  logic verify_status_lower;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  evs_state_t state;
  evs_state_t next_state;

  // decode
  wire is_cfg = wr_addr == OFF_CONFIG;
  wire is_stat = wr_addr == OFF_STATUS;
  wire is_idx = wr_addr == OFF_INDEX;
  wire is_par = wr_addr == OFF_PARAM;
  wire is_msk = wr_addr == OFF_MASK;
  assign wr_ok = is_cfg || is_stat || is_idx || is_par || is_msk || wr_addr == OFF_EVT;
  wire busy = state != EVS_IDLE;
  wire complete_irq_enable = config_reg[CFG_IRQEN_BIT];
  wire cmd_lock = config_reg[CFG_LOCK_BIT];

  // parameter bank is frozen while a command runs
  wire wr_open = wr_en && command_complete_flag;
  wire [31:0] stat_merged = merge_bytes(32'h0000_0000, wr_data, wr_strb);
  wire [31:0] par_merged = merge_bytes({16'h0000, command_param_word[param_index]},
                                       wr_data, wr_strb);
  wire [31:0] cfg_merged = merge_bytes({30'h0, config_reg}, wr_data, wr_strb);
  wire [31:0] idx_merged = merge_bytes({29'h0, param_index}, wr_data, wr_strb);
  wire [31:0] msk_merged = merge_bytes({29'h0, evt_mask}, wr_data, wr_strb);
  wire stat_wr = wr_en && is_stat;
  wire acc_clear = stat_wr && stat_merged[ST_ACCESS_BIT];
  // a pending access error must be cleared before a new launch
  wire launch = stat_wr && stat_merged[ST_COMPLETE_BIT] && command_complete_flag
                && !access_error_flag;

  // launch parameters
  wire [7:0] cmd_code = command_param_word[IDX_CMD][15:8];
  wire [5:0] addr_high_junk = command_param_word[IDX_CMD][7:2];
  wire [GADDR_W-1:0] g_addr = {command_param_word[IDX_CMD][1:0],
                               command_param_word[IDX_FIRST]};
  wire [15:0] word_count = command_param_word[IDX_COUNT];
  wire [19:0] sec_end = {2'b00, g_addr} + {3'b000, word_count, 1'b0};

  wire err_index = param_index != IDX_COUNT;
  wire err_mode = cmd_lock || cmd_code != CMD_SECTION_VERIFY;
  wire err_range = addr_high_junk != 6'h00 || g_addr < EE_START
                   || {2'b00, g_addr} >= EE_END;
  wire err_align = g_addr[0];
  wire err_breach = sec_end > EE_END;
  wire err_any = err_index || err_mode || err_range || err_align || err_breach;

  wire scan_start = state == EVS_CHECK && !err_any;
  logic scan_done;
  logic scan_any;
  logic scan_fatal;

  evs_scan u_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(scan_start),
    .first_addr(g_addr),
    .word_count(word_count),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid),
    .mem_ecc_fix(mem_ecc_fix),
    .mem_ecc_fatal(mem_ecc_fatal),
    .done(scan_done),
    .any_err(scan_any),
    .fatal_err(scan_fatal)
  );

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      EVS_IDLE: if (launch) next_state = EVS_CHECK;
      EVS_CHECK: next_state = err_any ? EVS_IDLE : EVS_SCAN;
      EVS_SCAN: if (scan_done) next_state = EVS_IDLE;
      default: next_state = EVS_IDLE;
    endcase
  end

  wire check_fail = state == EVS_CHECK && err_any;
  wire finish = check_fail || (state == EVS_SCAN && scan_done);
  wire vfail = state == EVS_SCAN && scan_done && scan_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= EVS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_complete_flag <= 1'b1;
    end else if (launch) begin
      command_complete_flag <= 1'b0;
    end else if (finish) begin
      command_complete_flag <= 1'b1;
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      access_error_flag <= 1'b0;
    end else if (check_fail) begin
      access_error_flag <= 1'b1;
    end else if (acc_clear) begin
      access_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verify_status_upper <= 1'b0;
      verify_status_lower <= 1'b0;
    end else if (launch) begin
      verify_status_upper <= 1'b0;
      verify_status_lower <= 1'b0;
    end else if (state == EVS_SCAN && scan_done) begin
      verify_status_upper <= scan_any;
      verify_status_lower <= scan_fatal;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= CONFIG_RST;
      param_index <= INDEX_RST;
      evt_mask <= MASK_RST;
    end else if (wr_en) begin
      if (is_cfg) config_reg <= cfg_merged[1:0];
      if (is_msk) evt_mask <= msk_merged[2:0];
      if (is_idx && command_complete_flag) param_index <= idx_merged[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_open && is_par) begin
      command_param_word[param_index] <= par_merged[15:0];
    end
  end

  // events, cleared by reading the event register; a new event still lands
  wire [2:0] evt_set;
  assign evt_set[EV_DONE_BIT] = finish;
  assign evt_set[EV_ACC_BIT] = check_fail;
  assign evt_set[EV_VFAIL_BIT] = vfail;
  wire evt_rd = rd_en && rd_addr == OFF_EVT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status <= '0;
    end else begin
      evt_status <= (evt_rd ? 3'h0 : evt_status) | evt_set;
    end
  end

  assign irq = (command_complete_flag && complete_irq_enable)
               || |(evt_status & evt_mask);

  // read side; the protection flag is never raised by this command
  wire [7:0] status_view = {command_complete_flag, 1'b0, access_error_flag, 1'b0,
                            busy, 1'b0, verify_status_upper, verify_status_lower};
  wire rd_cfg = rd_addr == OFF_CONFIG;
  wire rd_stat = rd_addr == OFF_STATUS;
  wire rd_idx = rd_addr == OFF_INDEX;
  wire rd_par = rd_addr == OFF_PARAM;
  wire rd_msk = rd_addr == OFF_MASK;
  assign rd_ok = rd_cfg || rd_stat || rd_idx || rd_par || rd_msk || evt_rd;
  assign rd_data = rd_cfg ? {30'h0, config_reg}
                 : rd_stat ? {24'h0, status_view}
                 : rd_idx ? {29'h0, param_index}
                 : rd_par ? {16'h0, command_param_word[param_index]}
                 : rd_msk ? {29'h0, evt_mask}
                 : rd_addr == OFF_EVT ? {29'h0, evt_status}
                 : 32'h0000_0000;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_launch_start: assert property (
    launch |=> state == EVS_CHECK && !command_complete_flag ##1 (busy || access_error_flag))
    else $error("launch did not start the check");

  chk_done_sets_flag: assert property (
    state == EVS_SCAN && scan_done |=> command_complete_flag && state == EVS_IDLE)
    else $error("complete flag not set after the check");

  chk_busy_clear: assert property (
    busy |-> !command_complete_flag)
    else $error("complete flag high while busy");

  chk_index_err: assert property (
    state == EVS_CHECK && param_index != IDX_COUNT |=> access_error_flag)
    else $error("bad index did not raise access error");

  chk_mode_err: assert property (
    state == EVS_CHECK && cmd_lock |=> access_error_flag && !busy)
    else $error("locked mode did not raise access error");

  chk_range_err: assert property (
    state == EVS_CHECK && ({2'b00, g_addr} >= EE_END || g_addr < EE_START)
    |=> access_error_flag)
    else $error("bad address did not raise access error");

  chk_align_err: assert property (
    state == EVS_CHECK && g_addr[0] |=> access_error_flag ##0 !verify_status_upper)
    else $error("odd address did not raise access error");

  chk_breach_err: assert property (
    state == EVS_CHECK && sec_end > EE_END |=> access_error_flag)
    else $error("section breach did not raise access error");

  chk_upper_status: assert property (
    state == EVS_SCAN && scan_done && scan_any |=> verify_status_upper)
    else $error("upper verify status missing");

  chk_lower_status: assert property (
    state == EVS_SCAN && scan_done && scan_fatal
    |=> verify_status_lower && verify_status_upper)
    else $error("lower verify status missing");

  chk_irq_level: assert property (
    $rose(command_complete_flag) && complete_irq_enable |-> irq)
    else $error("complete interrupt not requested");

  chk_error_skip: assert property (
    check_fail |=> command_complete_flag && !mem_req [*3])
    else $error("memory read after access error");

  chk_good_no_err: assert property (
    state == EVS_CHECK && !err_any |=> state == EVS_SCAN && !access_error_flag)
    else $error("valid launch flagged as error");
endmodule
`default_nettype wire

// [bench/eeprom_section_erase_verify_tb.sv]
`default_nettype none
module eeprom_section_erase_verify_tb import evs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] idx;
    logic lock;
    logic [17:0] first;
    logic [15:0] cnt;
    logic [1:0] kind;
    logic [17:0] bad;
    logic [2:0] exp;
  } evs_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mem_req, irq;
  logic [1:0] bresp, rresp, kind = 2'h0;
  logic [GADDR_W-1:0] mem_addr, bad = 18'h0;
  logic [15:0] mem_rdata = 16'h0;
  logic mem_rvalid = 1'b0, mem_ecc_fix = 1'b0, mem_ecc_fatal = 1'b0;
  int failures = 0, n_compared = 0, cyc = 0, reqs = 0;
  evs_row_t rows [13];

  evs_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .mem_ecc_fix(mem_ecc_fix), .mem_ecc_fatal(mem_ecc_fatal), .irq(irq)
  );

  always #5 aclk = ~aclk;

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // memory answers one cycle late, every other cycle; idle data toggles
  always @(posedge aclk) begin
    mem_rvalid <= aresetn && mem_req && !mem_rvalid;
    mem_rdata <= (mem_req && !mem_rvalid) ?
                 ((kind == 2'h1 && mem_addr == bad) ? 16'h0000 : ERASED_WORD) : ~mem_rdata;
    mem_ecc_fix <= kind == 2'h2 && mem_addr == bad;
    mem_ecc_fatal <= kind == 2'h3 && mem_addr == bad;
    if (mem_req)
      reqs <= reqs + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // readies sampled on the falling edge, where the comb outputs have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    check("bresp", {30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar, r;
    logic [1:0] rs;
    r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
    end
    check("rresp", {30'h0, rs}, {30'h0, er});
  endtask

  task automatic load(input logic [7:0] c, input logic [17:0] a, input logic [15:0] n,
                      input logic [2:0] ix);
    wr(OFF_INDEX, {29'h0, IDX_CMD}, RESP_OKAY);
    wr(OFF_PARAM, {16'h0, c, 6'h0, a[17:16]}, RESP_OKAY);
    wr(OFF_INDEX, {29'h0, IDX_FIRST}, RESP_OKAY);
    wr(OFF_PARAM, {16'h0, a[15:0]}, RESP_OKAY);
    wr(OFF_INDEX, {29'h0, IDX_COUNT}, RESP_OKAY);
    wr(OFF_PARAM, {16'h0, n}, RESP_OKAY);
    wr(OFF_INDEX, {29'h0, ix}, RESP_OKAY);
  endtask

  task automatic run(output logic [31:0] st);
    wr(OFF_STATUS, 32'h80, RESP_OKAY);
    st = 32'h0;
    for (int k = 0; k < 200 && st[ST_COMPLETE_BIT] !== 1'b1; k++)
      rd(OFF_STATUS, RESP_OKAY, st);
    #1;
  endtask

  initial begin
    evs_row_t r;
    logic [31:0] st, ev;
    int n0;
    logic [7:0] ro [5];
    logic [31:0] rv [5];
    ro = '{OFF_CONFIG, OFF_STATUS, OFF_INDEX, OFF_MASK, OFF_EVT};
    rv = '{32'h0, 32'h80, 32'h0, 32'h0, 32'h0};
    rows = '{
      '{8'h10, 3'h2, 1'h0, 18'h00400, 16'h0004, 2'h0, 18'h00000, 3'h0},
      '{8'h10, 3'h2, 1'h0, 18'h00400, 16'h0004, 2'h1, 18'h00404, 3'h3},
      '{8'h10, 3'h2, 1'h0, 18'h009fe, 16'h0001, 2'h2, 18'h009fe, 3'h2},
      '{8'h10, 3'h2, 1'h0, 18'h00500, 16'h0003, 2'h3, 18'h00502, 3'h3},
      '{8'h10, 3'h2, 1'h0, 18'h00400, 16'h0000, 2'h1, 18'h00400, 3'h0},
      '{8'h10, 3'h2, 1'h0, 18'h009fc, 16'h0002, 2'h0, 18'h00000, 3'h0},
      '{8'h10, 3'h1, 1'h0, 18'h00400, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h10, 3'h2, 1'h1, 18'h00400, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h11, 3'h2, 1'h0, 18'h00400, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h10, 3'h2, 1'h0, 18'h00401, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h10, 3'h2, 1'h0, 18'h003fe, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h10, 3'h2, 1'h0, 18'h10400, 16'h0001, 2'h0, 18'h00000, 3'h4},
      '{8'h10, 3'h2, 1'h0, 18'h009fe, 16'h0002, 2'h0, 18'h00000, 3'h4}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wr(OFF_CONFIG, {30'h0, r.lock, 1'b1}, RESP_OKAY);
      load(r.cmd, r.first, r.cnt, r.idx);
      kind <= r.kind;
      bad <= r.bad;
      n0 = reqs;
      run(st);
      check("complete", st[ST_COMPLETE_BIT], 1'b1);
      check("access_err", st[ST_ACCESS_BIT], r.exp[2]);
      check("protect", st[ST_PROTECT_BIT], 1'b0);
      check("mg1", st[ST_MG1_BIT], r.exp[1]);
      check("mg0", st[ST_MG0_BIT], r.exp[0]);
      check("irq", irq, 1'b1);
      rd(OFF_EVT, RESP_OKAY, ev);
      check("evt", ev[2:0], {r.exp[1], r.exp[2], 1'b1});
      // the memory answers every other cycle, so each word holds the request two cycles
      check("reqs", reqs - n0, r.exp[2] ? 0 : 2 * r.cnt);
      if (r.exp[2]) begin
        wr(OFF_STATUS, 32'h20, RESP_OKAY);
        rd(OFF_STATUS, RESP_OKAY, st);
        check("acc_clr", st[ST_ACCESS_BIT], 1'b0);
      end
      $display("test %0d done", i);
    end
    // second reset after the last test, registers other than the parameter bank back to their reset values
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ro[i]) begin
      rd(ro[i], RESP_OKAY, st);
      check("reset_val", st, rv[i]);
    end
    #1;
    check("irq_rst", irq, 1'b0);
    $display("test reset done");
    wr(OFF_CONFIG, 32'h1, RESP_OKAY);
    #1;
    check("irq_en", irq, 1'b1);
    wr(OFF_CONFIG, 32'h0, RESP_OKAY);
    #1;
    check("irq_off", irq, 1'b0);
    wr(OFF_MASK, 32'h1, RESP_OKAY);
    load(CMD_SECTION_VERIFY, 18'h00400, 16'h0001, IDX_COUNT);
    kind <= 2'h0;
    run(st);
    check("irq_evt", irq, 1'b1);
    rd(OFF_EVT, RESP_OKAY, ev);
    #1;
    check("irq_clr", irq, 1'b0);
    $display("test irq done");
    wr(8'h18, 32'h1, RESP_SLVERR);
    rd(8'h18, RESP_SLVERR, st);
    $display("test unmapped done");
    results();
  end
endmodule
`default_nettype wire
